// >>> rss_pkg.sv
/*
 Package for the reset strap sampler: strap field layout, defaults, timing
 counts, sequencer states and the packed carriers shared by the sampler, checker, board model and bench.
 Assumes a single 20 MHz platform clock that keeps running after reset release.
*/
// Functional notes
// RULE_01: During hard reset every strap pin is an input and is never driven.
// RULE_02: Each strap level is captured as hard reset deasserts and used as config.
// RULE_03: After capture the strap input receivers turn off and pins resume output duty.
// RULE_04: Gated pull-ups are on during hard reset plus a few clocks after release.
// RULE_05: Pull-up of a strap pin turns off together with its input receiver.
// RULE_06: A high sampled level on a pulled-up strap selects the default setting.
// RULE_07: Clock multiplier ratio straps have no internal pull-up; board sets them.
// RULE_08: Board must keep the first Ethernet transmit data pins high in reset.
// RULE_09: Board must assert the test-port reset during system reset.
// RULE_10: Test port controller also resets by holding test mode select high five clocks.
// RULE_11: Captured values hold until the next hard reset and recapture on each release.
package rss_pkg;
   localparam int unsigned CLK_HZ         = 20_000_000;
   localparam int unsigned PU_HOLD_NS     = 200;
   localparam int unsigned CLK_NS         = 1_000_000_000 / CLK_HZ;
   localparam int unsigned PU_HOLD_CYC_I  = (PU_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned PU_HOLD_CYC    = (PU_HOLD_CYC_I < 1) ? 1 : PU_HOLD_CYC_I;
   localparam int unsigned HOLD_W         = 4;

   // Strap field layout
   localparam int unsigned PLAT_RATIO_W   = 4;
   localparam int unsigned CORE_RATIO_W   = 2;
   localparam int unsigned ETH1_TXD_W     = 4;
   localparam int unsigned GEN_W          = 6;
   localparam int unsigned STRAP_W        = PLAT_RATIO_W + CORE_RATIO_W + ETH1_TXD_W + GEN_W;
   localparam int unsigned PLAT_LSB       = 0;
   localparam int unsigned CORE_LSB       = PLAT_LSB + PLAT_RATIO_W;
   localparam int unsigned ETH_LSB        = CORE_LSB + CORE_RATIO_W;
   localparam int unsigned GEN_LSB        = ETH_LSB + ETH1_TXD_W;

   // Pins carrying gated pull-ups: everything but the two ratio fields
   localparam logic [STRAP_W-1:0] PULLUP_MASK = 16'hFFC0;
   localparam logic [STRAP_W-1:0] CFG_RST     = 16'hFFC0;

   localparam int unsigned TMS_RST_CNT    = 5;
   localparam int unsigned TMS_CNT_W      = 3;

   typedef enum logic [1:0] {
      RSS_ST_RESET,
      RSS_ST_HOLD,
      RSS_ST_RUN
   } rss_state_e;

   typedef struct packed {
      logic [GEN_W-1:0]        general;
      logic [ETH1_TXD_W-1:0]   eth1_tx_data;
      logic [CORE_RATIO_W-1:0] core_ratio;
      logic [PLAT_RATIO_W-1:0] plat_ratio;
   } rss_cfg_s;

   typedef struct packed {
      logic [STRAP_W-1:0] oe;
      logic [STRAP_W-1:0] rx_en;
      logic [STRAP_W-1:0] pu_en;
   } rss_pad_s;
endpackage : rss_pkg

// >>> rss_sync2.sv
/*
 Two-flop level synchroniser, width parameterised.
 Assumes the input is asynchronous to i_clk; only the second stage is read.
*/
`timescale 1ns/1ns
module rss_sync2 #(
   parameter int unsigned W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         meta_r <= INIT;
         o_q    <= INIT;
      end else begin
         meta_r <= i_d;
         o_q    <= meta_r;
      end
   end
endmodule : rss_sync2

// >>> rss_strap_sampler.sv
/*
 Reset strap sampler: turns the strap pins to inputs during hard reset,
 latches them as reset is released, then returns pins to functional output.
 Also keeps the test-port controller reset, by its own reset or by test mode
 select held high over test clock edges.
 Assumes hard reset and test pins are asynchronous; i_clk runs through release.
 Strap pins pass the same two-flop latency as hard reset, so the level taken
 is the one the pins held in the cycle the release was seen.
 The test clock is oversampled by i_clk and must run far slower than it.
 Pad controls are decoded from the state register and synchronised hard reset,
 and may glitch only when either changes, never while a pin is being sampled.
*/
`timescale 1ns/1ns
module rss_strap_sampler #(
   parameter int unsigned HOLD_CYC = rss_pkg::PU_HOLD_CYC
) (
   input  wire logic                         i_clk,
   input  wire logic                         i_sys_rst,
   input  wire logic                         i_hard_reset_n,
   input  wire logic [rss_pkg::STRAP_W-1:0]  i_strap_pin,
   input  wire logic [rss_pkg::STRAP_W-1:0]  i_func_out,
   input  wire logic                         i_test_rst_n,
   input  wire logic                         i_test_clk,
   input  wire logic                         i_test_mode_sel,
   output logic      [rss_pkg::STRAP_W-1:0]  o_strap_out,
   output rss_pkg::rss_pad_s                 o_pad,
   output rss_pkg::rss_cfg_s                 o_cfg,
   output logic                              o_cfg_valid,
   output logic                              o_tap_reset
);
   localparam int unsigned SW = rss_pkg::STRAP_W;

   logic [SW-1:0]                  strap_s;
   logic                           hard_reset_n_n_s;
   logic                           trst_n_s;
   logic                           tck_s;
   logic                           tms_s;
   rss_pkg::rss_state_e            state_r;
   rss_pkg::rss_state_e            state_nxt;
   logic [rss_pkg::HOLD_W-1:0]     hold_r;
   logic [rss_pkg::HOLD_W-1:0]     hold_nxt;
   logic [SW-1:0]                  cfg_r;
   logic                           tck_d_r;
   logic [rss_pkg::TMS_CNT_W-1:0]  tms_cnt_r;
   logic [rss_pkg::TMS_CNT_W-1:0]  tms_cnt_nxt;
   logic                           tap_rst_r;
   logic                           tap_rst_nxt;

   // Same latency as hard reset, so capture sees the level of the release cycle
   rss_sync2 #(.W(SW), .INIT(rss_pkg::CFG_RST)) u_strap_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_d       (i_strap_pin),
      .o_q       (strap_s)
   );

   // Both resets start asserted so nothing is driven before the first clocks
   rss_sync2 #(.W(2), .INIT(2'h0)) u_rst_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_d       ({i_hard_reset_n, i_test_rst_n}),
      .o_q       ({hard_reset_n_n_s, trst_n_s})
   );

   // Test clock is oversampled; a fast test clock would lose edges here
   rss_sync2 #(.W(2), .INIT(2'h0)) u_tap_sync (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .i_d       ({i_test_clk, i_test_mode_sel}),
      .o_q       ({tck_s, tms_s})
   );

   // Sequencer: reset -> hold (pull-ups kept briefly) -> run
   wire in_reset  = ~hard_reset_n_n_s;
   wire st_reset  = (state_r == rss_pkg::RSS_ST_RESET);
   wire st_hold   = (state_r == rss_pkg::RSS_ST_HOLD);
   wire st_run    = (state_r == rss_pkg::RSS_ST_RUN);
   wire hold_done = (hold_r == rss_pkg::HOLD_W'(HOLD_CYC - 1));
   wire capture   = st_reset & hard_reset_n_n_s;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         rss_pkg::RSS_ST_RESET: begin
            if (hard_reset_n_n_s) begin
               state_nxt = rss_pkg::RSS_ST_HOLD;
            end
         end
         rss_pkg::RSS_ST_HOLD: begin
            if (in_reset) begin
               state_nxt = rss_pkg::RSS_ST_RESET;
            end else if (hold_done) begin
               state_nxt = rss_pkg::RSS_ST_RUN;
            end
         end
         rss_pkg::RSS_ST_RUN: begin
            // A fresh hard reset reopens sampling for the next capture
            if (in_reset) begin
               state_nxt = rss_pkg::RSS_ST_RESET; // [RULE_11]
            end
         end
         default: begin
            state_nxt = rss_pkg::RSS_ST_RESET;
         end
      endcase
   end

   // Counts only while holding; every other state parks it at zero
   assign hold_nxt = st_hold ? (hold_r + 1'b1) : '0;

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_r <= rss_pkg::RSS_ST_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         hold_r <= '0;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   // Last level seen in reset is the one latched on release; held till next reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         cfg_r <= rss_pkg::CFG_RST;
      end else if (capture) begin
         cfg_r <= strap_s; // [RULE_02] [RULE_11] [RULE_06]
      end
   end

   // Pads: receivers live through hold; capture is already taken in the reset state, on release
   wire          sampling = ~st_run;
   wire          drive    = st_run & hard_reset_n_n_s;
   wire [SW-1:0] oe_all   = {SW{drive}};
   wire [SW-1:0] rx_all   = {SW{sampling}};
   // Pull-ups follow the receivers; ratio straps have none and rely on the board
   wire [SW-1:0] pu_gate  = rx_all & rss_pkg::PULLUP_MASK;

   assign o_pad.oe    = oe_all;  // [RULE_01] [RULE_03]
   assign o_pad.rx_en = rx_all;  // [RULE_03]
   assign o_pad.pu_en = pu_gate; // [RULE_04] [RULE_05] [RULE_07]

   // Pad data is registered so a pin never shows a combinational glitch
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_strap_out <= '0;
      end else begin
         o_strap_out <= i_func_out;
      end
   end

   // Field view of the captured word, kept to the package layout
   assign o_cfg.plat_ratio   = cfg_r[rss_pkg::PLAT_LSB +: rss_pkg::PLAT_RATIO_W];
   assign o_cfg.core_ratio   = cfg_r[rss_pkg::CORE_LSB +: rss_pkg::CORE_RATIO_W];
   assign o_cfg.eth1_tx_data = cfg_r[rss_pkg::ETH_LSB +: rss_pkg::ETH1_TXD_W];
   assign o_cfg.general      = cfg_r[rss_pkg::GEN_LSB +: rss_pkg::GEN_W];
   assign o_cfg_valid        = st_run;

   // Test-port reset: dedicated reset, or test mode select high on five test clock rises
   wire tck_rise = tck_s & ~tck_d_r;
   wire tms_last = (tms_cnt_r == rss_pkg::TMS_CNT_W'(rss_pkg::TMS_RST_CNT - 1));

   // Dedicated reset wins over any test clock activity in the same cycle
   always_comb begin
      tms_cnt_nxt = tms_cnt_r;
      tap_rst_nxt = tap_rst_r;
      if (!trst_n_s) begin
         tms_cnt_nxt = '0;
         tap_rst_nxt = 1'b1;
      end else if (tck_rise) begin
         if (!tms_s) begin
            tms_cnt_nxt = '0;
            tap_rst_nxt = 1'b0;
         end else if (tms_last) begin
            tap_rst_nxt = 1'b1; // [RULE_10]
         end else begin
            tms_cnt_nxt = tms_cnt_r + 1'b1;
         end
      end
   end

   // Idle level of the test clock is low, so no false edge follows reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tck_d_r <= 1'b0;
      end else begin
         tck_d_r <= tck_s;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tms_cnt_r <= '0;
         tap_rst_r <= 1'b1;
      end else begin
         tms_cnt_r <= tms_cnt_nxt;
         tap_rst_r <= tap_rst_nxt;
      end
   end

   assign o_tap_reset = tap_rst_r; // [RULE_09]
endmodule : rss_strap_sampler

// >>> rss_props.sv
/* Port checker for the strap sampler, bound into every instance.
 Assumes the bench holds strap pins steady around hard reset release. */
`timescale 1ns/1ns
module rss_props #(
   parameter int unsigned HOLD_CYC = 4
) (
   input wire logic                 i_clk,
   input wire logic                 i_sys_rst,
   input wire logic                 i_hard_reset_n,
   input wire logic [15:0]          i_strap_pin,
   input wire logic                 i_test_rst_n,
   input wire logic                 i_test_clk,
   input wire logic                 i_test_mode_sel,
   input wire rss_pkg::rss_pad_s    o_pad,
   input wire rss_pkg::rss_cfg_s    o_cfg,
   input wire logic                 o_cfg_valid,
   input wire logic                 o_tap_reset
);
   logic [2:0] tms_cnt_r;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Raw test clock rises with select high; a low rise restarts the count
   always_ff @(posedge i_clk)
      if (i_sys_rst || !i_test_rst_n) tms_cnt_r <= 3'h0;
      else if ($rose(i_test_clk)) tms_cnt_r <= i_test_mode_sel ? tms_cnt_r + 3'h1 : 3'h0;
   sequence s_up;
      $rose(i_hard_reset_n) ##0 ($stable(i_strap_pin) && i_hard_reset_n)[*6];
   endsequence
   sequence s_tck_quiet;
      ##1 (i_test_rst_n && $stable(i_test_clk))[*6];
   endsequence
   AST_NO_DRIVE: assert property (!i_hard_reset_n[*5] |-> o_pad.oe == '0 && o_pad.rx_en == '1)
      else $error("strap pin driven during hard reset");
   AST_CAPTURE: assert property (s_up |-> o_cfg == i_strap_pin)
      else $error("captured config differs from strap level");
   AST_PU_LATE: assert property ($rose(i_hard_reset_n) ##1 i_hard_reset_n[*6]
      |-> o_pad.pu_en == rss_pkg::PULLUP_MASK && !o_cfg_valid)
      else $error("pull-ups dropped too early after release");
   AST_VALID: assert property ($rose(i_hard_reset_n) ##1 i_hard_reset_n[*8] |=> o_cfg_valid)
      else $error("pins not handed back after release");
   AST_HANDBACK: assert property ($rose(o_cfg_valid) |-> o_pad.oe == '1 && o_pad.rx_en == '0
      && $past(o_pad.pu_en) == rss_pkg::PULLUP_MASK)
      else $error("hand-back does not switch pad controls together");
   AST_PU_RX: assert property (o_pad.pu_en == (o_pad.rx_en & rss_pkg::PULLUP_MASK))
      else $error("pull-up not tied to receiver enable");
   AST_HOLD: assert property (o_cfg_valid && $past(o_cfg_valid) |-> $stable(o_cfg))
      else $error("captured config changed while running");
   AST_TAP_RST: assert property (!i_test_rst_n[*4] |-> o_tap_reset)
      else $error("test controller not reset by test reset");
   AST_TMS: assert property (($rose(i_test_clk) && i_test_mode_sel && tms_cnt_r == 3'h4)
      ##0 s_tck_quiet |-> o_tap_reset)
      else $error("five select-high clocks did not reset test controller");
   AST_TMS_LOW: assert property (($rose(i_test_clk) && !i_test_mode_sel) ##0 s_tck_quiet
      |-> !o_tap_reset)
      else $error("select-low clock did not release test controller");
endmodule : rss_props
bind rss_strap_sampler rss_props #(.HOLD_CYC(HOLD_CYC)) u_props (.i_clk, .i_sys_rst, .i_hard_reset_n,
   .i_strap_pin, .i_test_rst_n, .i_test_clk, .i_test_mode_sel, .o_pad, .o_cfg, .o_cfg_valid, .o_tap_reset);

// >>> rss_board.sv
/* Board model: strap resistors and pin levels seen by the sampler.
 Assumes a zero strap bit is a pull-down stronger than the internal pull-up. */
`timescale 1ns/1ns
module rss_board (
   input wire logic                 i_clk,
   input wire logic [15:0]          i_strap,
   input wire rss_pkg::rss_pad_s    i_pad,
   input wire logic [15:0]          i_out,
   output logic     [15:0]          o_pin
);
   logic [15:0] lvl;
   logic [15:0] flt;
   logic [15:0] last_r = '0;
   assign lvl = i_strap | 16'h03C0; // Transmit data pins kept high
   // Ratio pins are always strapped by the board
   assign flt = ~i_pad.oe & lvl & ~i_pad.pu_en & rss_pkg::PULLUP_MASK;
   // Undriven pins with no pull keep no clean level
   assign o_pin = (i_pad.oe & i_out) | (~i_pad.oe & ~flt & lvl) | (flt & ~last_r);
   always_ff @(posedge i_clk) last_r <= o_pin;
endmodule : rss_board

// >>> tb_rss_strap_sampler.sv
/* Testbench for the strap sampler with the board model.
 Assumes the default hold count; inputs change on the falling edge. */
`timescale 1ns/1ns
module tb_rss_strap_sampler;
   logic i_clk = 0, i_sys_rst = 1, hrst_n = 0, trst_n = 0, tck = 0, tms = 0, valid, tap;
   logic [15:0] strap = 16'hFFFF, func = '0, pin, out, exp_cfg;
   rss_pkg::rss_pad_s pad;
   rss_pkg::rss_cfg_s cfg;
   int n_fail = 0, n_checks = 0, cyc = 0, seed;
   rss_strap_sampler dut (.i_clk, .i_sys_rst, .i_hard_reset_n(hrst_n), .i_strap_pin(pin), .i_func_out(func),
      .i_test_rst_n(trst_n), .i_test_clk(tck), .i_test_mode_sel(tms), .o_strap_out(out), .o_pad(pad),
      .o_cfg(cfg), .o_cfg_valid(valid), .o_tap_reset(tap));
   rss_board board (.i_clk, .i_strap(strap), .i_pad(pad), .i_out(out), .o_pin(pin));
   initial forever #25 i_clk = ~i_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick
   task automatic pulse;
      tck = 1;
      tick(8);
      tck = 0;
      tick(8);
   endtask : pulse
   task automatic final_report;
      $display("checks=%0d fails=%0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Board straps with the transmit data pins forced high
   function automatic logic [15:0] expect_cfg(input logic [15:0] s);
      return s | 16'h03C0;
   endfunction : expect_cfg
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      seed = $urandom(71979);
      tick(8);
      i_sys_rst = 0;
      for (int k = 0; k < 6; k++) begin
         hrst_n = 0;
         trst_n = 0;
         strap = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : 16'($urandom);
         tick(6);
         chk(pad.oe, 16'h0000);
         chk(pin, expect_cfg(strap));
         chk({15'h0, tap}, 16'h0001);
         hrst_n = 1;
         tick(10);
         exp_cfg = expect_cfg(strap);
         chk(cfg, exp_cfg);
         chk({15'h0, valid} | pad.pu_en | pad.rx_en, 16'h0001);
         strap = 16'($urandom);
         func = 16'($urandom);
         tick(3);
         chk(pin, func);
         chk(cfg, exp_cfg);
      end
      trst_n = 1;
      pulse();
      chk({15'h0, tap}, 16'h0000);
      tms = 1;
      repeat (4) pulse();
      chk({15'h0, tap}, 16'h0000);
      pulse();
      chk({15'h0, tap}, 16'h0001);
      final_report();
   end
endmodule : tb_rss_strap_sampler
